// ===== src/apdc_consts.vh
// constants for the automatic power-down control block
`ifndef APDC_CONSTS_VH
`define APDC_CONSTS_VH
`define APDC_CNT_W          4
`define APDC_IDLE_LIMIT     4'hF
`define APDC_PMR0_RESET     8'h00
`define APDC_PMR2_RESET     8'h00
`define APDC_PMR0_SLEEP_EN  1
`define APDC_PMR0_SLOW      3
`define APDC_PMR0_ARR_CLK   4
`define APDC_PMR0_MC_CLK    5
`define APDC_PMR2_CNTL0     2
`define APDC_PMR2_CNTL1     3
`define APDC_PMR2_CNTL2     4
`define APDC_PMR2_STROBE    5
`define APDC_PMR2_DBE       6
`endif

// ===== src/apdc_auto_power_down.v
// automatic power-down unit with power-mode registers and gating
`timescale 1ns/10ps
`include "apdc_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - sleep unit idle counter, four bits wide
// - counter sampled by the clock-input pin
// - fifteen idle periods raise power-down flag
// - sleep enable alone arms power-down
// - strobe activity ends power-down
// - select low or reset high wakes
// - block bus, deselect memories while down
// - clock-input block spares the idle counter
// - memories standby, logic stays active, ports hold or float
// - logic speed set only by full-speed bit
// - pins: hold, or tri-state for data and peripheral pins
// - select high disables memories and io space
// - select never blocks signals or logic arrays
// - host writes mode regs; blocking bits gate
// - full-speed default on; bit set turns off
// - register zero bit 1 enables sleep unit
// - register zero bit 3 disables full speed
// - pulsing strobe halts count; steady strobe counts
////////////////////////////////////////////////////////////////////////////////
module apdc_auto_power_down #(
  parameter CNT_W = `APDC_CNT_W
) (
  // clock and power-up reset
  input  wire       clk,
  input  wire       rstn,
  // host side: register writes and bus
  input  wire       modeWrZero,
  input  wire       modeWrTwo,
  input  wire [7:0] modeWrData,
  input  wire [7:0] hostAddrData,
  // device pins, asynchronous to clk
  input  wire       strobePin,
  input  wire       clockPin,
  input  wire       selectPin,
  input  wire       resetPin,
  // port pin behaviour controls
  input  wire [7:0] portOutIn,
  input  wire       portIsDataOrPeriph,
  // outputs
  output reg  [7:0] powerModeRegZero,
  output reg  [7:0] powerModeRegTwo,
  output reg        powerDownFlag,
  output reg  [7:0] memBusOut,
  output reg  [7:0] arrayBusOut,
  output reg        memSelect,
  output reg        ioSpaceSelect,
  output reg        fullSpeed,
  output reg        arrayClkEn,
  output reg        macroClkEn,
  output reg  [4:0] ctrlToArrayEn,
  output reg  [7:0] portOut,
  output reg        portOutEnN
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, a change counts once stages two and three agree
reg [2:0] strobeSync;
reg [2:0] clkSync;
reg [2:0] selSync;
reg [2:0] rstSync;
reg       strobeLvl;
reg       clkLvl;
reg       clkLvlDly;
reg       selLvl;
reg       rstLvl;
reg       strobeEdge;

// stages two and three agree, so the pin has settled past metastability
function settled;
  input [2:0] sync;
  begin
    settled = (sync[1] == sync[2]);
  end
endfunction

// reset levels match each pin's idle level so no false edge follows reset
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    strobeSync <= 3'h0;
    strobeLvl  <= 1'b0;
  end else begin
    strobeSync <= {strobeSync[1:0], strobePin};
    if (settled(strobeSync)) strobeLvl <= strobeSync[2];
  end
end

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    clkSync    <= 3'h0;
    clkLvl     <= 1'b0;
    clkLvlDly  <= 1'b0;
  end else begin
    clkSync    <= {clkSync[1:0], clockPin};
    if (settled(clkSync)) clkLvl <= clkSync[2];
    clkLvlDly  <= clkLvl;
  end
end

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    selSync    <= 3'h7;
    selLvl     <= 1'b1;
  end else begin
    selSync    <= {selSync[1:0], selectPin};
    if (settled(selSync)) selLvl <= selSync[2];
  end
end

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    rstSync    <= 3'h0;
    rstLvl     <= 1'b0;
  end else begin
    rstSync    <= {rstSync[1:0], resetPin};
    if (settled(rstSync)) rstLvl <= rstSync[2];
  end
end

wire clkRise   = clkLvl & ~clkLvlDly;
wire strobeNow = settled(strobeSync) & (strobeSync[2] != strobeLvl);

// held until the next clock-input rise so a pulse between rises is seen;
// a new strobe edge wins over the clearing rise in the same cycle
always @(posedge clk or negedge rstn) begin
  if (!rstn) strobeEdge <= 1'b0;
  else if (strobeNow) strobeEdge <= 1'b1;
  else if (clkRise) strobeEdge <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// power-mode registers: rstn is the power-up reset; the reset pin does not touch them
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    powerModeRegZero <= `APDC_PMR0_RESET;
    powerModeRegTwo  <= `APDC_PMR2_RESET;
  end else begin
    if (modeWrZero) powerModeRegZero <= modeWrData;
    if (modeWrTwo) powerModeRegTwo <= modeWrData;
  end
end

wire sleepEn = powerModeRegZero[`APDC_PMR0_SLEEP_EN];

////////////////////////////////////////////////////////////////////////////////
// idle counter, advanced on clock-input rising edges regardless of the array clock gate
localparam [CNT_W-1:0] IDLE_LIMIT = `APDC_IDLE_LIMIT;
localparam [CNT_W-1:0] IDLE_LAST  = `APDC_IDLE_LIMIT - 4'h1;

reg [CNT_W-1:0] idleCnt;
reg [CNT_W-1:0] next_idleCnt;
reg             next_powerDownFlag;
wire            wake = strobeEdge | strobeNow | ~selLvl | rstLvl;

// counter saturates so a long sleep never wraps back to awake
always @* begin
  next_idleCnt       = idleCnt;
  next_powerDownFlag = powerDownFlag;
  if (!sleepEn || wake) begin
    next_idleCnt       = {CNT_W{1'b0}};
    next_powerDownFlag = 1'b0;
  end else if (clkRise) begin
    if (idleCnt == IDLE_LAST) next_powerDownFlag = 1'b1;
    if (idleCnt != IDLE_LIMIT) next_idleCnt = idleCnt + 1'b1;
  end
end

always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    idleCnt       <= {CNT_W{1'b0}};
    powerDownFlag <= 1'b0;
  end else begin
    idleCnt       <= next_idleCnt;
    powerDownFlag <= next_powerDownFlag;
  end
end

////////////////////////////////////////////////////////////////////////////////
// gating of bus, selects, clocks and pins
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    memBusOut     <= 8'h00;
    arrayBusOut   <= 8'h00;
    memSelect     <= 1'b0;
    ioSpaceSelect <= 1'b0;
    portOut       <= 8'h00;
    portOutEnN    <= 1'b1;
  end else begin
    // bus frozen while down so the memories and arrays see no toggling
    if (!powerDownFlag) begin
      memBusOut   <= hostAddrData;
      arrayBusOut <= hostAddrData;
    end
    memSelect     <= ~powerDownFlag & ~selLvl;
    ioSpaceSelect <= ~powerDownFlag & ~selLvl;
    // io and logic outputs hold; data and peripheral pins float
    if (!powerDownFlag) portOut <= portOutIn;
    portOutEnN    <= powerDownFlag & portIsDataOrPeriph;
  end
end

// array controls: select and power-down leave the array untouched
always @(posedge clk or negedge rstn) begin
  if (!rstn) begin
    fullSpeed     <= 1'b1;
    arrayClkEn    <= 1'b1;
    macroClkEn    <= 1'b1;
    ctrlToArrayEn <= 5'h1F;
  end else begin
    fullSpeed     <= ~powerModeRegZero[`APDC_PMR0_SLOW];
    arrayClkEn    <= ~powerModeRegZero[`APDC_PMR0_ARR_CLK];
    macroClkEn    <= ~powerModeRegZero[`APDC_PMR0_MC_CLK];
    ctrlToArrayEn <= ~powerModeRegTwo[`APDC_PMR2_DBE:`APDC_PMR2_CNTL0];
  end
end

endmodule // apdc_auto_power_down

// ===== verification/apdc_host_model.sv
// host pins model: strobe, free clock input and address/data bus
`timescale 1ns/10ps
module apdc_host_model (
  // bench clock and host activity
  input            clk,
  input            busy,
  // pins towards the unit
  output reg       strobePin = 1'h0,
  output reg       clockPin = 1'h0,
  output reg [7:0] hostAddrData = 8'h00
);
  reg [3:0] n = 4'h0;
  // crystal-style clock runs free, since a sleeping host cannot stop it
  always @(posedge clk) begin
    n <= #1 n + 4'h1;
    clockPin <= #1 n[3];
    if (busy && n == 4'h7) strobePin <= #1 !strobePin;
    hostAddrData <= #1 $urandom;
  end
endmodule // apdc_host_model

// ===== verification/apdc_auto_power_down_properties.sv
// assertions on the power-down unit ports
`timescale 1ns/10ps
module apdc_props (
  // clock and reset
  input       clk,
  input       rstn,
  // watched ports
  input       modeWrZero,
  input [7:0] modeWrData,
  input [7:0] powerModeRegZero,
  input       powerDownFlag,
  input       memSelect,
  input       ioSpaceSelect,
  input       fullSpeed,
  input       portIsDataOrPeriph,
  input       portOutEnN,
  input [7:0] memBusOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_wr_zero: assert property (modeWrZero |=> powerModeRegZero == $past(modeWrData))
    else $error("write lost");
  chk_reg_hold: assert property (!modeWrZero |=> $stable(powerModeRegZero))
    else $error("reg changed");
  chk_speed_bit: assert property (fullSpeed == !$past(powerModeRegZero[3]))
    else $error("speed wrong");
  chk_down_desel: assert property (powerDownFlag |=> !memSelect)
    else $error("still selected");
  chk_io_follow: assert property (ioSpaceSelect == memSelect)
    else $error("io select");
  chk_bus_freeze: assert property (powerDownFlag |=> $stable(memBusOut))
    else $error("bus moved");
  chk_port_float: assert property (powerDownFlag && portIsDataOrPeriph |=> portOutEnN)
    else $error("port driven");
  chk_sleep_off: assert property (!powerModeRegZero[1] [*8] |-> !powerDownFlag)
    else $error("slept");
  cover property (powerDownFlag);
  cover property ($fell(powerDownFlag));
  cover property (modeWrZero);
endmodule // apdc_props
bind apdc_auto_power_down apdc_props apdc_props_inst (.*);

// ===== verification/tb_auto_power_down_control.sv
// self-checking bench for the power-down unit
`timescale 1ns/10ps
module tb_auto_power_down_control;
  reg        clk, rstn, modeWrZero, modeWrTwo, selectPin, resetPin, busy, portIsDataOrPeriph;
  reg  [7:0] modeWrData, portOutIn, d, e;
  reg  [7:0] wrQ[$];
  integer    modelReg0 = 0, modelReg2 = 0;
  wire [7:0] powerModeRegZero, powerModeRegTwo, memBusOut, hostAddrData, arrayBusOut, portOut;
  wire [4:0] ctrlToArrayEn;
  wire       strobePin, clockPin, powerDownFlag, memSelect, ioSpaceSelect, fullSpeed;
  wire       arrayClkEn, macroClkEn, portOutEnN;
  integer    errors = 0, checksDone = 0, i;
  apdc_auto_power_down apdc_auto_power_down_inst (.*);
  apdc_host_model apdc_host_model_inst (.*);
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task check(input [7:0] seen, exp);
    checksDone = checksDone + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // settle past the pin synchronisers after the last clock-input rise
  task rises(input integer n);
    repeat (n) @(posedge clockPin);
    step(8);
  endtask
  task report_and_stop;
    if (errors == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    {rstn, modeWrZero, modeWrTwo, resetPin, modeWrData} = 12'h000;
    {selectPin, busy, portIsDataOrPeriph} = 3'h7;
    i = $urandom(64);
    portOutIn = $urandom;
    step(2);
    rstn = 1;
    check(powerModeRegZero, 8'h00);
    repeat (4) begin
      d = (i == 0) ? 8'h02 : $urandom;
      {modeWrZero, modeWrTwo, modeWrData} = {2'h3, d};
      wrQ.push_back(d);
      step(1);
      {modeWrZero, modeWrTwo, resetPin} = 3'h1;
      modelReg0 = wrQ[0];
      modelReg2 = wrQ.pop_front();
      step(2);
      resetPin = 0;
      check(powerModeRegTwo, modelReg2[7:0]);
      check(ctrlToArrayEn, {3'h0, ~d[6:2]});
      check(fullSpeed, !d[3]);
      check({macroClkEn, arrayClkEn}, {~d[5:4]});
      check(powerModeRegZero, modelReg0[7:0]);
      i = 0;
    end
    // margins of one rise absorb where the last strobe edge lands
    for (i = 0; i < 3; i = i + 1) begin
      busy = 0;
      rises(13);
      check(powerDownFlag, 0);
      rises(3);
      check(powerDownFlag, 1);
      d = memBusOut;
      e = portOutIn;
      portOutIn = ~portOutIn;
      step(4);
      check(memSelect, 0);
      check(ioSpaceSelect, 0);
      check(portOutEnN, 1);
      check(memBusOut, d);
      check(arrayBusOut, d);
      check(portOut, e);
      {selectPin, resetPin, busy} = (i == 0) ? 3'h0 : (i == 1) ? 3'h6 : 3'h5;
      step(40);
      check(powerDownFlag, 0);
      check(memSelect, !selectPin);
      check(portOut, portOutIn);
      {selectPin, resetPin} = 2'h2;
    end
    report_and_stop;
  end
endmodule // tb_auto_power_down_control
